// file: src/frm_pkg.sv
// Purpose: Constants for the floppy routing and MIDI base register block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Printed offsets are not all multiples of four, so they are indices

package frm_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] FRM_IDX_MIDI_HIGH = 8'h60;
	localparam logic [7:0] FRM_IDX_MIDI_LOW = 8'h61;
	localparam logic [7:0] FRM_IDX_ROUTE = 8'hf1;
	localparam logic [7:0] FRM_IDX_STATUS = 8'hf2;

	// Reset values
	localparam logic [7:0] FRM_RST_MIDI_HIGH = 8'h03;
	localparam logic [7:0] FRM_RST_MIDI_LOW = 8'h30;
	localparam logic [1:0] FRM_RST_ROUTE = 2'h0;

	// Writable masks
	localparam logic [7:0] FRM_MASK_MIDI_HIGH = 8'h0f;
	localparam logic [7:0] FRM_MASK_MIDI_LOW = 8'hfe;

	// Routing field codes
	localparam logic [1:0] FRM_ROUTE_BY_MODE = 2'h0;
	localparam logic [1:0] FRM_ROUTE_PIN_SPLIT = 2'h1;
	localparam logic [1:0] FRM_ROUTE_PIN_BOTH = 2'h2;
	localparam logic [1:0] FRM_ROUTE_RESERVED = 2'h3;

	// Drive placement per drive
	typedef enum logic [1:0] {
		FRM_DRV_OFF,
		FRM_DRV_FLOPPY_PINS,
		FRM_DRV_PARALLEL_PINS
	} frm_place_e;

endpackage : frm_pkg

// file: src/frm_regs.sv
// Purpose: Floppy-on-parallel routing selector and MIDI base address bytes
// Assumes: APB slave, zero wait states, 32-bit data, pclk 20 MHz
// Notes: Unmapped addresses read zero and answer pslverr
//
// How it works
// [R1] Code 00: parallel port mode bits steer routing, select pin ignored.
// [R2] Code 01, pin low: drive 0 on floppy pins, drive 1 on parallel.
// [R3] Code 10, pin low: both drives on parallel pins; 11 reserved.
// [R4] Select pin active low: low enables floppy use, high keeps parallel.
// [R5] MIDI high byte holds address bits 11..8 in bits 3..0, rest zero.
// [R6] MIDI low byte holds address bits 7..1; bit 0 always zero.
// [R7] Routing register bits 7..2 read zero and ignore writes.

`timescale 1ns/100ps
`default_nettype none

module frm_regs
	import frm_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Routing inputs
	input wire logic floppy_parallel_route_select,
	input wire logic [1:0] parallel_port_mode_bits,
	// Routing outputs
	output logic [1:0] drive0_place,
	output logic [1:0] drive1_place,
	output logic floppy_on_parallel_en,
	// MIDI base address
	output logic [11:0] midi_base_addr
);

	logic [3:0] midi_high_r;
	logic [6:0] midi_low_r;
	logic [1:0] route_r;
	logic pin_sync;
	logic [7:0] idx;
	logic hit;
	logic wr_en;
	logic [31:0] rdata_nxt;
	logic [1:0] d0_nxt;
	logic [1:0] d1_nxt;
	logic [1:0] par_nxt;

	frm_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(floppy_parallel_route_select),
		.rst_val(1'b1),
		.q(pin_sync)
	);

	assign idx = paddr[9:2];
	assign hit = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
		((idx == FRM_IDX_MIDI_HIGH) || (idx == FRM_IDX_MIDI_LOW) ||
		(idx == FRM_IDX_ROUTE) || (idx == FRM_IDX_STATUS));
	// Writes take effect at the access-phase edge only
	assign wr_en = psel && penable && pwrite && hit && pstrb[0];

	// MIDI base, address bits 11..8; upper nibble has no storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			midi_high_r <= FRM_RST_MIDI_HIGH[3:0];
		end else if (wr_en && (idx == FRM_IDX_MIDI_HIGH)) begin
			midi_high_r <= pwdata[3:0]; // [R5]
		end
	end

	// MIDI base, address bits 7..1; bit 0 has no storage, base stays even
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			midi_low_r <= FRM_RST_MIDI_LOW[7:1];
		end else if (wr_en && (idx == FRM_IDX_MIDI_LOW)) begin
			midi_low_r <= pwdata[7:1]; // [R6]
		end
	end

	// Routing field; bits 7..2 have no storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route_r <= FRM_RST_ROUTE;
		end else if (wr_en && (idx == FRM_IDX_ROUTE)) begin
			route_r <= pwdata[1:0]; // [R7]
		end
	end

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (idx)
			FRM_IDX_MIDI_HIGH: rdata_nxt = {28'h000_0000, midi_high_r}; // [R5]
			FRM_IDX_MIDI_LOW: rdata_nxt = {24'h00_0000, midi_low_r, 1'b0}; // [R6]
			FRM_IDX_ROUTE: rdata_nxt = {30'h0000_0000, route_r}; // [R7]
			FRM_IDX_STATUS: rdata_nxt = {24'h00_0000, 1'b0, pin_sync,
				drive1_place, drive0_place, floppy_on_parallel_en, 1'b0};
			default: rdata_nxt = 32'h0000_0000;
		endcase
		if (!hit) begin
			rdata_nxt = 32'h0000_0000;
		end
	end

	// Answer registered in the setup cycle, valid through access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
			pready <= 1'b1;
			pslverr <= !hit;
		end else begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Routing decode: one lane per drive, high when it goes to parallel pins
	for (genvar g = 0; g < 2; g++) begin : g_lane
		logic par_lane;
		always_comb begin
			par_lane = 1'b0;
			case (route_r)
				FRM_ROUTE_BY_MODE: begin
					par_lane = parallel_port_mode_bits[g]; // [R1]
				end
				FRM_ROUTE_PIN_SPLIT: begin
					// Only drive 1 moves; pin high keeps the port [R4]
					par_lane = (g == 1) && !pin_sync; // [R2]
				end
				FRM_ROUTE_PIN_BOTH: begin
					par_lane = !pin_sync; // [R3] [R4]
				end
				default: begin
					// Reserved code leaves the parallel port alone
					par_lane = 1'b0; // [R3]
				end
			endcase
		end
		assign par_nxt[g] = par_lane;
	end

	assign d0_nxt = par_nxt[0] ? FRM_DRV_PARALLEL_PINS : FRM_DRV_FLOPPY_PINS;
	assign d1_nxt = par_nxt[1] ? FRM_DRV_PARALLEL_PINS : FRM_DRV_FLOPPY_PINS;

	// Drive placement outputs, one edge after the decode settles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive0_place <= FRM_DRV_FLOPPY_PINS;
			drive1_place <= FRM_DRV_FLOPPY_PINS;
			floppy_on_parallel_en <= 1'b0;
		end else begin
			drive0_place <= d0_nxt;
			drive1_place <= d1_nxt;
			floppy_on_parallel_en <= |par_nxt;
		end
	end

	// MIDI base address seen by the decoder, even by construction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			midi_base_addr <= {FRM_RST_MIDI_HIGH[3:0], FRM_RST_MIDI_LOW};
		end else begin
			midi_base_addr <= {midi_high_r, midi_low_r, 1'b0}; // [R6]
		end
	end

	logic unused_ok;
	assign unused_ok = (|pwdata[31:8]) | (|pstrb[3:1]);

endmodule : frm_regs

`default_nettype wire

// file: src/frm_sync.sv
// Purpose: Two-stage synchroniser for one level from outside the clock
// Assumes: Async active-low reset
// Notes: First stage feeds only the second

`timescale 1ns/100ps
`default_nettype none

module frm_sync (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Level
	input wire logic d,
	input wire logic rst_val,
	output logic q
);

	logic meta_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= 1'b1;
			q <= 1'b1;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end

	logic unused_rst_val;
	assign unused_rst_val = rst_val;

endmodule : frm_sync

`default_nettype wire

// file: test/frm_regs_asserts.sv
// Purpose: Port checker for the routing and MIDI base block
// Assumes: Routing code mirrored from APB writes
// Notes: Pin paths allow two sync stages and one output stage
`timescale 1ns/100ps
`default_nettype none
module frm_regs_chk (
	input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire logic floppy_parallel_route_select, floppy_on_parallel_en,
	input wire logic [1:0] parallel_port_mode_bits, drive0_place,
	input wire logic [1:0] drive1_place,
	input wire logic [3:0] pstrb,
	input wire logic [11:0] paddr, midi_base_addr,
	input wire logic [31:0] pwdata, prdata
);
	logic [1:0] cd_r, pm_r;
	logic wr, pin;
	assign wr = psel && penable && pwrite && pstrb[0];
	assign pin = floppy_parallel_route_select;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cd_r <= 2'h0;
			pm_r <= 2'h0;
		end else begin
			pm_r <= parallel_port_mode_bits;
			if (wr && paddr == 12'h3c4) cd_r <= pwdata[1:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_mode_steer: assert property (
		cd_r == 2'h0 |=> {drive1_place, drive0_place} ==
		{pm_r[1], !pm_r[1], pm_r[0], !pm_r[0]}) else $error("mode routing");
	a_pin_split: assert property (
		(cd_r == 2'h1 && !pin)[*3] |=> drive0_place == 2'h1 &&
		drive1_place == 2'h2) else $error("split routing");
	a_pin_both: assert property (
		(cd_r == 2'h2 && !pin)[*3] |=> drive0_place == 2'h2 &&
		drive1_place == 2'h2) else $error("both routing");
	a_pin_high: assert property (
		(cd_r[1] != cd_r[0] && pin)[*3] |=> !floppy_on_parallel_en &&
		drive0_place == 2'h1) else $error("pin high routing");
	a_code_rsvd: assert property (
		cd_r == 2'h3 |=> drive0_place == 2'h1 && drive1_place == 2'h1)
		else $error("reserved code routing");
	a_midi_high: assert property (
		wr && paddr == 12'h180 |=> ##1 midi_base_addr[11:8] ==
		$past(pwdata[3:0], 2)) else $error("midi high byte");
	a_midi_low: assert property (
		wr && paddr == 12'h184 |=> ##1 midi_base_addr[7:0] ==
		{$past(pwdata[7:1], 2), 1'b0}) else $error("midi low byte");
	a_ready_access: assert property (
		pready == (psel && penable)) else $error("ready timing");
	c_split: cover property (cd_r == 2'h1 && !pin);
	c_both: cover property (cd_r == 2'h2 && !pin);
	c_midi: cover property (wr && paddr == 12'h180);
endmodule : frm_regs_chk
bind frm_regs frm_regs_chk u_frm_regs_chk (.*);
`default_nettype wire

// file: test/frm_regs_tb.sv
// Purpose: Self-checking bench for the routing and MIDI base block
// Assumes: APB master waits for pready at 20 MHz
// Notes: Routing sampled after the pin synchroniser latency
`timescale 1ns/100ps
`default_nettype none
module frm_regs_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic floppy_parallel_route_select = 1, pready, pslverr, e;
	logic floppy_on_parallel_en;
	logic [1:0] parallel_port_mode_bits = '0, drive0_place, drive1_place;
	logic [11:0] paddr = '0, midi_base_addr;
	logic [31:0] pwdata = '0, prdata, q;
	logic [3:0] pstrb = 4'hf;
	int n_mismatch = 0, compares = 0;
	frm_regs u_frm_regs (.*);
	initial forever #25 pclk = ~pclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			k++;
			@(posedge pclk);
		end
		chk(32'(k), 32'h0000_0000);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'h0;
	endtask : xfer
	task automatic t_regs;
		logic [11:0] a[4] = '{12'h180, 12'h184, 12'h3c4, 12'h3d0};
		logic [7:0] r[4] = '{8'h03, 8'h30, 8'h00, 8'h00};
		logic [7:0] m[4] = '{8'h0f, 8'hfe, 8'h03, 8'h00};
		logic [31:0] d[4] = '{32'hffff_ffff, 32'hffff_fffe, 32'hffff_ffff,
			32'hffff_ffff};
		chk(32'(midi_base_addr), 32'h0000_0330);
		for (int i = 0; i < 4; i++) begin
			xfer(1'b0, a[i], 32'h0000_0000);
			chk(q, 32'(r[i]));
			xfer(1'b1, a[i], d[i]);
			xfer(1'b0, a[i], 32'h0000_0000);
			chk(q, 32'(m[i]));
			chk(32'(e), 32'(i == 3));
		end
		chk(32'(midi_base_addr), 32'h0000_0ffe);
	endtask : t_regs
	task automatic t_route;
		logic [3:0] x;
		for (logic [5:0] i = 0; i < 32; i++) begin
			xfer(1'b1, 12'h3c4, {30'h0, i[1:0]});
			floppy_parallel_route_select <= i[2];
			parallel_port_mode_bits <= i[4:3];
			repeat (5) @(negedge pclk);
			if (i[1:0] == 2'h0) x = {i[4], !i[4], i[3], !i[3]};
			else if (!i[2] && i[1:0] != 2'h3) x = {2'h2, i[1], !i[1]};
			else x = 4'h5;
			chk(32'({drive1_place, drive0_place}), 32'(x));
			chk(32'(floppy_on_parallel_en), 32'(x[3] | x[1]));
			xfer(1'b0, 12'h3c8, 32'h0000_0000);
			chk(q, {24'h00_0000, 1'b0, i[2], x, x[3] | x[1], 1'b0});
		end
	endtask : t_route
	task automatic give_verdict;
		if (n_mismatch == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict
	initial begin
		#100_000;
		n_mismatch++;
		give_verdict;
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_route;
		give_verdict;
	end
endmodule : frm_regs_tb
`default_nettype wire
